/* shared/pif_pkg.sv */
package pif_pkg;
	// register indices; the bus byte address is index times four
	localparam logic [7:0] FLAG_IDX = 8'h95;
	localparam logic [7:0] WAKE_IDX = 8'h96;
	localparam logic [9:0] FLAG_ADDR = {FLAG_IDX, 2'b00};
	localparam logic [9:0] WAKE_ADDR = {WAKE_IDX, 2'b00};
	localparam logic [9:0] CTRL_ADDR = 10'h000;
	localparam logic [9:0] IST_ADDR = 10'h004;
	localparam logic [9:0] IMSK_ADDR = 10'h008;
	// flag bit positions
	localparam int TK_BIT = 5;
	localparam int AD_BIT = 4;
	localparam int EX_BIT = 2;
	localparam int P1_BIT = 1;
	localparam int T3_BIT = 0;
	localparam logic [7:0] FLAG_USED = 8'h37;
	// control register bits
	localparam int CTRL_EXT_EN = 0;
	localparam int CTRL_P1_EN = 1;
	localparam int CTRL_T3_EN = 2;
	// reset values
	localparam logic [7:0] FLAG_RST = 8'h00;
	localparam logic [7:0] WAKE_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [4:0] IST_RST = 5'h00;
	localparam logic [4:0] IMSK_RST = 5'h00;
	localparam logic [7:0] P1_RST = 8'hFF;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

/* core/pif_flags.sv */
`timescale 1ns/100ps
// What this block does
// - touch-key done sets flag bit 5
// - write DFh or touch start clears it
// - conversion done sets flag bit 4
// - write EFh or conversion start clears it
// - pin two falling edge sets bit 2 always
// - pin two flag clears on vector or FBh
// - enabled port1 pin change sets bit 1
// - port1 irq enable gates request only
// - port1 flag clears on vector or FDh
// - timer3 period sets flag bit 0
// - timer3 flag clears on vector or FEh
// - per-pin wake enable register at 96h
module pif_flags
	import pif_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic touch_key_done,
	input wire logic touch_key_start_bit,
	input wire logic conversion_done,
	input wire logic conversion_start_bit,
	input wire logic ext_irq_two_pin,
	input wire logic [7:0] port_one_pins,
	input wire logic third_timer_period,
	input wire logic ack_ext_two,
	input wire logic ack_port_one,
	input wire logic ack_third_timer,
	output logic req_ext_two,
	output logic req_port_one,
	output logic req_third_timer,
	output logic irq
);

	////////////////////////////////////////////////////////////////////
	// pin synchronisers: three stages, change counts when 2nd and 3rd agree
	logic [8:0] sync1, sync2, sync3, stable;
	logic [8:0] next_stable;
	logic primed, next_primed;

	always_comb
	begin
		next_stable = stable;
		for (int i = 0; i < 9; i++)
		begin
			if (sync2[i] == sync3[i])
				next_stable[i] = sync3[i];
		end
		next_primed = 1'b1;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sync1 <= {1'b1, P1_RST};
			sync2 <= {1'b1, P1_RST};
			sync3 <= {1'b1, P1_RST};
			stable <= {1'b1, P1_RST};
			primed <= 1'b0;
		end
		else
		begin
			sync1 <= {ext_irq_two_pin, port_one_pins};
			sync2 <= sync1;
			sync3 <= sync2;
			stable <= next_stable;
			primed <= next_primed;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] flags, wake_en, ctrl;
	logic [4:0] ist, imsk;
	logic [7:0] next_flags, next_wake_en, next_ctrl;
	logic [4:0] next_ist, next_imsk;
	logic [31:0] next_dat;
	logic next_ack;
	logic [7:0] set_ev, clr_ev;
	logic wr, rd, byte0;
	logic [7:0] wbyte;
	logic [4:0] ev5;

	function automatic logic [4:0] pack5(input logic [7:0] f);
		pack5 = {f[TK_BIT], f[AD_BIT], f[EX_BIT], f[P1_BIT], f[T3_BIT]};
	endfunction

	always_comb
	begin
		wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
		rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
		byte0 = wb_sel_i[0];
		wbyte = wb_dat_i[7:0];
		set_ev = 8'h00;
		set_ev[TK_BIT] = touch_key_done;
		set_ev[AD_BIT] = conversion_done;
		// falling edge seen whatever ext_irq_two_enable holds
		set_ev[EX_BIT] = primed && stable[8] && !next_stable[8];
		// only pins with wake enable count; irq enable not involved
		set_ev[P1_BIT] = primed &&
			|((stable[7:0] ^ next_stable[7:0]) & wake_en);
		set_ev[T3_BIT] = third_timer_period;
		clr_ev = 8'h00;
		clr_ev[TK_BIT] = touch_key_start_bit;
		clr_ev[AD_BIT] = conversion_start_bit;
		clr_ev[EX_BIT] = ack_ext_two;
		clr_ev[P1_BIT] = ack_port_one;
		clr_ev[T3_BIT] = ack_third_timer;
		if (wr && byte0 && wb_adr_i[9:0] == FLAG_ADDR)
			clr_ev = clr_ev | ~wbyte;
		// set beats a clear in the same cycle
		next_flags = ((flags & ~clr_ev) | set_ev) & FLAG_USED;
		next_wake_en = wake_en;
		next_ctrl = ctrl;
		next_imsk = imsk;
		ev5 = pack5(set_ev);
		next_ist = ist | ev5;
		if (wr && byte0)
		begin
			case (wb_adr_i[9:0])
				WAKE_ADDR: next_wake_en = wbyte;
				CTRL_ADDR: next_ctrl = wbyte;
				IMSK_ADDR: next_imsk = wbyte[4:0];
				IST_ADDR: next_ist = (ist & ~wbyte[4:0]) | ev5;
				default: ;
			endcase
		end
		next_ack = wr || rd;
		next_dat = UNMAPPED_DATA;
		if (rd)
		begin
			case (wb_adr_i[9:0])
				FLAG_ADDR: next_dat = {24'h00_0000, flags};
				WAKE_ADDR: next_dat = {24'h00_0000, wake_en};
				CTRL_ADDR: next_dat = {24'h00_0000, ctrl};
				IST_ADDR: next_dat = {27'h000_0000, ist};
				IMSK_ADDR: next_dat = {27'h000_0000, imsk};
				default: next_dat = UNMAPPED_DATA;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			flags <= FLAG_RST;
			wake_en <= WAKE_RST;
			ctrl <= CTRL_RST;
			ist <= IST_RST;
			imsk <= IMSK_RST;
			wb_ack_o <= 1'b0;
			wb_dat_o <= UNMAPPED_DATA;
			req_ext_two <= 1'b0;
			req_port_one <= 1'b0;
			req_third_timer <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			flags <= next_flags;
			wake_en <= next_wake_en;
			ctrl <= next_ctrl;
			ist <= next_ist;
			imsk <= next_imsk;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			req_ext_two <= next_flags[EX_BIT] && next_ctrl[CTRL_EXT_EN];
			// enable gates only the request, never the flag
			req_port_one <= next_flags[P1_BIT] && next_ctrl[CTRL_P1_EN];
			req_third_timer <= next_flags[T3_BIT] && next_ctrl[CTRL_T3_EN];
			irq <= |(next_ist & next_imsk);
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	logic flag_wr;
	assign flag_wr = wr && byte0 && wb_adr_i[9:0] == FLAG_ADDR;

	a_tk_set: assert property (@(posedge sys_clk) disable iff (rst)
		touch_key_done |=> flags[TK_BIT])
		else $error("touch flag not set");
	a_tk_clear: assert property (@(posedge sys_clk) disable iff (rst)
		touch_key_start_bit && !touch_key_done |=> !flags[TK_BIT])
		else $error("touch flag not cleared");
	a_ad_set: assert property (@(posedge sys_clk) disable iff (rst)
		conversion_done |=> flags[AD_BIT])
		else $error("conversion flag not set");
	a_ad_clear: assert property (@(posedge sys_clk) disable iff (rst)
		conversion_start_bit && !conversion_done |=> !flags[AD_BIT])
		else $error("conversion flag not cleared");
	a_ex_edge: assert property (@(posedge sys_clk) disable iff (rst)
		primed && stable[8] && sync2[8] == 1'b0 && sync3[8] == 1'b0
		|=> flags[EX_BIT])
		else $error("edge flag missed");
	a_ex_ack: assert property (@(posedge sys_clk) disable iff (rst)
		ack_ext_two && !set_ev[EX_BIT] |=> !flags[EX_BIT])
		else $error("edge flag kept after vector");
	a_p1_mask: assert property (@(posedge sys_clk) disable iff (rst)
		!flags[P1_BIT] && wake_en == 8'h00 && !ack_port_one
		|=> !flags[P1_BIT])
		else $error("disabled pin set change flag");
	a_p1_req: assert property (@(posedge sys_clk) disable iff (rst)
		!ctrl[CTRL_P1_EN] && !next_ctrl[CTRL_P1_EN] |=> !req_port_one)
		else $error("request without enable");
	a_p1_ack: assert property (@(posedge sys_clk) disable iff (rst)
		ack_port_one && !set_ev[P1_BIT] |=> !flags[P1_BIT])
		else $error("change flag kept after vector");
	a_t3_set: assert property (@(posedge sys_clk) disable iff (rst)
		third_timer_period |=> flags[T3_BIT])
		else $error("timer flag not set");
	a_t3_ack: assert property (@(posedge sys_clk) disable iff (rst)
		ack_third_timer && !third_timer_period |=> !flags[T3_BIT])
		else $error("timer flag kept after vector");
	a_wake_wr: assert property (@(posedge sys_clk) disable iff (rst)
		wr && byte0 && wb_adr_i[9:0] == WAKE_ADDR |=>
		wake_en == $past(wb_dat_i[7:0]))
		else $error("wake enable not stored");
	a_wr_keep: assert property (@(posedge sys_clk) disable iff (rst)
		flag_wr && wbyte[T3_BIT] && flags[T3_BIT] && !ack_third_timer
		|=> flags[T3_BIT])
		else $error("written one cleared a flag");
	a_ack_once: assert property (@(posedge sys_clk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	////////////////////////////////////////////////////////////////////
	// bus, request gating, rising edge, software clears and wake enable hold
	a_ack_take: assert property (@(posedge sys_clk) disable iff (rst)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked");
	a_ack_idle: assert property (@(posedge sys_clk) disable iff (rst)
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_dat_idle: assert property (@(posedge sys_clk) disable iff (rst)
		!wb_ack_o |-> wb_dat_o == UNMAPPED_DATA)
		else $error("read data outside ack");
	a_ex_free: assert property (@(posedge sys_clk) disable iff (rst)
		set_ev[EX_BIT] && !ctrl[CTRL_EXT_EN] |=> flags[EX_BIT])
		else $error("edge flag needs enable");
	a_ex_rise: assert property (@(posedge sys_clk) disable iff (rst)
		primed && !stable[8] && sync2[8] && sync3[8] && !flags[EX_BIT]
		|=> !flags[EX_BIT])
		else $error("rising edge set flag");
	a_p1_free: assert property (@(posedge sys_clk) disable iff (rst)
		set_ev[P1_BIT] && !ctrl[CTRL_P1_EN] |=> flags[P1_BIT])
		else $error("change flag needs enable");
	a_p1_gate: assert property (@(posedge sys_clk) disable iff (rst)
		req_port_one |-> flags[P1_BIT] && ctrl[CTRL_P1_EN])
		else $error("change request ungated");
	a_ext_gate: assert property (@(posedge sys_clk) disable iff (rst)
		req_ext_two |-> flags[EX_BIT] && ctrl[CTRL_EXT_EN])
		else $error("edge request ungated");
	a_t3_gate: assert property (@(posedge sys_clk) disable iff (rst)
		req_third_timer |-> flags[T3_BIT] && ctrl[CTRL_T3_EN])
		else $error("timer request ungated");
	a_tk_wr: assert property (@(posedge sys_clk) disable iff (rst)
		flag_wr && !wbyte[TK_BIT] && !touch_key_done
		|=> !flags[TK_BIT])
		else $error("touch flag kept after write");
	a_ad_wr: assert property (@(posedge sys_clk) disable iff (rst)
		flag_wr && !wbyte[AD_BIT] && !conversion_done
		|=> !flags[AD_BIT])
		else $error("conversion flag kept after write");
	a_ex_wr: assert property (@(posedge sys_clk) disable iff (rst)
		flag_wr && !wbyte[EX_BIT] && !set_ev[EX_BIT]
		|=> !flags[EX_BIT])
		else $error("edge flag kept after write");
	a_p1_wr: assert property (@(posedge sys_clk) disable iff (rst)
		flag_wr && !wbyte[P1_BIT] && !set_ev[P1_BIT]
		|=> !flags[P1_BIT])
		else $error("change flag kept after write");
	a_t3_wr: assert property (@(posedge sys_clk) disable iff (rst)
		flag_wr && !wbyte[T3_BIT] && !third_timer_period
		|=> !flags[T3_BIT])
		else $error("timer flag kept after write");
	a_ist_w1c: assert property (@(posedge sys_clk) disable iff (rst)
		wr && byte0 && wb_adr_i[9:0] == IST_ADDR && wbyte[T3_BIT]
		&& !third_timer_period |=> !ist[0])
		else $error("status bit kept after write one");
	a_wake_keep: assert property (@(posedge sys_clk) disable iff (rst)
		!(wr && byte0 && wb_adr_i[9:0] == WAKE_ADDR)
		|=> $stable(wake_en))
		else $error("wake enable changed without write");

	c_tk: cover property (@(posedge sys_clk) disable iff (rst)
		touch_key_done ##1 flag_wr);
	c_edge: cover property (@(posedge sys_clk) disable iff (rst)
		set_ev[EX_BIT] ##[1:20] ack_ext_two);
	c_p1: cover property (@(posedge sys_clk) disable iff (rst)
		set_ev[P1_BIT] && clr_ev[P1_BIT]);
	c_irq: cover property (@(posedge sys_clk) disable iff (rst)
		irq ##[1:20] !irq);
	c_t3_vec: cover property (@(posedge sys_clk) disable iff (rst)
		req_third_timer ##[1:8] ack_third_timer);

endmodule

/* test/pif_cpu_model.sv */
`timescale 1ns/100ps
module pif_cpu_model
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic en,
	input wire logic [2:0] req,
	output logic [2:0] ack
);
	// holdoff lets the registered request fall before the next vector
	logic [1:0] hold;
	logic [1:0] next_hold;
	logic [2:0] next_ack;
	always_comb
	begin
		next_ack = 3'h0;
		next_hold = (hold != 2'h0) ? hold - 2'h1 : hold;
		if (en && hold == 2'h0 && req != 3'h0)
		begin
			next_ack = req & (~req + 3'h1);
			next_hold = 2'h3;
		end
	end
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ack <= 3'h0;
			hold <= 2'h0;
		end
		else
		begin
			ack <= next_ack;
			hold <= next_hold;
		end
	end
endmodule

/* test/pif_flags_tb_top.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) \
	begin \
		samples_checked++; \
		if ((e) !== (g)) \
		begin \
			mismatches++; \
			$display("Error %s exp %h got %h", n, e, g); \
		end \
	end
module pif_flags_tb_top
	import pif_pkg::*;
;
	logic sys_clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, ack, irq;
	logic td = 0, ts = 0, cd = 0, cs = 0, ext = 1, tp = 0, cpu_en = 0;
	logic [31:0] adr = 0, wdat = 0, rdat, rd;
	logic [7:0] p1 = 8'hff;
	logic [2:0] req, cack;
	int mismatches = 0, samples_checked = 0;
	logic [7:0] vals [5] = '{8'hdf, 8'hef, 8'hfb, 8'hfd, 8'hfe};
	pif_flags u_pif_flags (.sys_clk(sys_clk), .rst(rst), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
		.touch_key_done(td), .touch_key_start_bit(ts),
		.conversion_done(cd), .conversion_start_bit(cs),
		.ext_irq_two_pin(ext), .port_one_pins(p1), .third_timer_period(tp),
		.ack_ext_two(cack[2]), .ack_port_one(cack[1]),
		.ack_third_timer(cack[0]), .req_ext_two(req[2]),
		.req_port_one(req[1]), .req_third_timer(req[0]), .irq(irq));
	pif_cpu_model u_pif_cpu_model (.sys_clk(sys_clk), .rst(rst),
		.en(cpu_en), .req(req), .ack(cack));
	initial forever #5 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
		int i;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {22'h0, a};
		wdat <= {24'h0, d};
		// ack and read data are taken at the rising edge that sees ack
		i = 0;
		do
		begin
			@(posedge sys_clk);
			i++;
		end
		while (ack !== 1'b1 && i < 20);
		if (ack !== 1'b1)
		begin
			mismatches++;
			finish_test();
		end
		else
		begin
			rd = rdat;
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask
	task rdchk(input string n, input logic [9:0] a, input logic [31:0] e);
		xfer(1'b0, a, 8'h00);
		`CHK(n, e, rd)
	endtask
	// pin edges go through a synchroniser, so allow settle time
	task fire;
		@(posedge sys_clk);
		{td, cd, tp, ext} <= 4'h0 | 4'he;
		p1[0] <= ~p1[0];
		@(posedge sys_clk);
		{td, cd, tp} <= 3'h0;
		repeat (8) @(posedge sys_clk);
		ext <= 1'b1;
		repeat (8) @(posedge sys_clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#500000;
		mismatches++;
		finish_test();
	end
	initial
	begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rdchk("flag", FLAG_ADDR, {24'h0, FLAG_RST});
		rdchk("wake", WAKE_ADDR, {24'h0, WAKE_RST});
		rdchk("unmapped", 10'h100, UNMAPPED_DATA);
		$display("test reset done");
		xfer(1'b1, WAKE_ADDR, 8'hfe);
		rdchk("wake", WAKE_ADDR, 32'h0000_00fe);
		fire();
		rdchk("flag", FLAG_ADDR, 32'h0000_0035);
		xfer(1'b1, WAKE_ADDR, 8'h01);
		fire();
		rdchk("flag", FLAG_ADDR, 32'h0000_0037);
		`CHK("req_port_one", 1'b0, req[1])
		$display("test events done");
		foreach (vals[k])
		begin
			fire();
			xfer(1'b1, FLAG_ADDR, vals[k]);
			rdchk("flag", FLAG_ADDR, {24'h0, vals[k] & 8'h37});
		end
		@(posedge sys_clk);
		{ts, cs} <= 2'h3;
		@(posedge sys_clk);
		{ts, cs} <= 2'h0;
		rdchk("flag", FLAG_ADDR, 32'h0000_0006);
		$display("test clears done");
		xfer(1'b1, CTRL_ADDR, 8'h07);
		cpu_en <= 1'b1;
		fire();
		repeat (20) @(posedge sys_clk);
		rdchk("flag", FLAG_ADDR, 32'h0000_0030);
		cpu_en <= 1'b0;
		xfer(1'b1, CTRL_ADDR, 8'h00);
		$display("test vector done");
		xfer(1'b1, IMSK_ADDR, 8'h1f);
		repeat (3) @(negedge sys_clk);
		`CHK("irq", 1'b1, irq)
		xfer(1'b1, IMSK_ADDR, 8'h00);
		repeat (3) @(negedge sys_clk);
		`CHK("irq", 1'b0, irq)
		xfer(1'b1, IMSK_ADDR, 8'h1f);
		xfer(1'b1, IST_ADDR, 8'h1f);
		repeat (3) @(negedge sys_clk);
		`CHK("irq", 1'b0, irq)
		rdchk("status", IST_ADDR, 32'h0000_0000);
		$display("test irq done");
		finish_test();
	end
endmodule
